//--- rtl/bmc_cache.v
`timescale 1ns/1ps
`include "bmc_consts.vh"

module bmc_cache #(
  parameter IDX_W      = `BMC_IDX_W,
  parameter TAG_W      = `BMC_TAG_W,
  parameter TMO_W      = `BMC_TMO_W,
  parameter TMO_CYCLES = `BMC_TMO_CYC
) (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_i,
  // CPU request
  input  wire        cpu_req_i,
  input  wire        cpu_we_i,
  input  wire        cpu_io_i,
  input  wire [31:0] cpu_addr_i,
  input  wire [3:0]  cpu_be_i,
  input  wire [31:0] cpu_wdata_i,
  // CPU answer
  output reg         cpu_ack_o,
  output reg         cpu_err_o,
  output reg  [31:0] cpu_rdata_o,
  // Board straps
  input  wire        real_mode_i,
  input  wire [1:0]  eprom_ws_i,
  input  wire [1:0]  mod_en_i,
  input  wire [1:0]  mod0_size_i,
  input  wire [1:0]  mod1_size_i,
  // DRAM port
  output reg         mem_req_o,
  output reg         mem_we_o,
  output reg  [21:0] mem_addr_o,
  output reg  [3:0]  mem_be_o,
  output reg  [31:0] mem_wdata_o,
  output reg  [3:0]  mem_wpar_o,
  input  wire        mem_ack_i,
  input  wire [31:0] mem_rdata_i,
  input  wire [3:0]  mem_rpar_i,
  // Local bus
  output reg         lb_req_o,
  output reg         lb_we_o,
  output reg  [1:0]  lb_space_o,
  output reg  [23:0] lb_addr_o,
  output reg  [1:0]  lb_be_o,
  output reg  [15:0] lb_wdata_o,
  input  wire        lb_ack_i,
  input  wire [15:0] lb_rdata_i,
  // Event pulses
  output reg         par_irq_o,
  output reg         tmo_irq_o
);

  // Derived geometry and the last count before a timeout
  localparam ENTRIES = 1 << IDX_W;
  localparam TAG_LSB = `BMC_IDX_LSB + IDX_W;
  localparam integer TMO_END = TMO_CYCLES - 1;
  localparam [TMO_W-1:0] TMO_LAST = TMO_END[TMO_W-1:0];

  // Odd parity bit per byte lane
  function [3:0] bmc_par4;
    input [31:0] d;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        bmc_par4[i] = ~^d[8*i +: 8];
      end
    end
  endfunction

  // Module size in bytes, zero when absent
  function [24:0] bmc_msize;
    input       en;
    input [1:0] code;
    begin
      bmc_msize = en ? (`BMC_MB << code) : 25'h0;
    end
  endfunction

  // Cache storage
  reg [31:0]      c_data  [0:ENTRIES-1];
  reg [TAG_W-1:0] c_tag   [0:ENTRIES-1];
  reg [ENTRIES-1:0] c_valid;

  // Controller state
  reg [1:0]       state;
  reg             r_we;
  reg [31:0]      r_addr;
  reg [3:0]       r_be;
  reg [31:0]      r_wdata;
  reg [1:0]       r_space;
  reg             r_cache;
  reg             hi_half;
  reg [TMO_W-1:0] wait_cnt;

  // Cache write port
  reg             wr_en;
  reg [IDX_W-1:0] wr_idx;
  reg [TAG_W-1:0] wr_tag;
  reg [31:0]      wr_data;
  reg [3:0]       wr_mask;

  // Address decode
  wire [24:0] dram_total = bmc_msize(mod_en_i[0], mod0_size_i)
                         + bmc_msize(mod_en_i[1], mod1_size_i); // R10
  wire top_real = &cpu_addr_i[`BMC_REAL_TOP:`BMC_EPROM_LSB];
  wire top_prot = &cpu_addr_i[`BMC_ADDR_MSB:`BMC_EPROM_LSB];
  // Top 128KB of either space, two sites
  wire is_eprom = ~cpu_io_i & (real_mode_i ? top_real : top_prot); // R12 R13

  // DRAM window and its cached low part
  wire low16m   = ~|cpu_addr_i[`BMC_ADDR_MSB:`BMC_DRAM_LSB];
  wire in_dram  = {1'b0, cpu_addr_i[`BMC_DRAM_LSB-1:0]} < dram_total;
  wire is_dram  = ~cpu_io_i & ~is_eprom & low16m & in_dram; // R10
  wire cacheable = is_dram & ~|cpu_addr_i[`BMC_DRAM_LSB-1:`BMC_CACHE_LSB];
  wire exp_page = cpu_addr_i[`BMC_IOPG_MSB:`BMC_IOPG_LSB] == `BMC_EXP_PAGE;

  // Local bus space of the request
  wire [1:0] space = is_eprom ? `BMC_SP_EPROM :
                     cpu_io_i ? (exp_page ? `BMC_SP_EXP : `BMC_SP_IO) :
                     `BMC_SP_SYS; // R11

  // Index and tag lookup
  wire [IDX_W-1:0] idx   = cpu_addr_i[`BMC_IDX_LSB +: IDX_W]; // R6
  wire [TAG_W-1:0] tag   = cpu_addr_i[TAG_LSB +: TAG_W];
  wire hit = cacheable & c_valid[idx] & (c_tag[idx] == tag); // R5

  // Index and tag of the held request, used by the fill
  wire [IDX_W-1:0] r_idx = r_addr[`BMC_IDX_LSB +: IDX_W];
  wire [TAG_W-1:0] r_tag = r_addr[TAG_LSB +: TAG_W];

  // Read parity check over all lanes
  wire par_ok = bmc_par4(mem_rdata_i) == mem_rpar_i; // R9

  // Local bus completion terms
  wire [TMO_W-1:0] ws_last = {{(TMO_W-3){1'b0}}, `BMC_WS_MIN + {1'b0, eprom_ws_i}};
  wire lb_slow  = (r_space == `BMC_SP_SYS) | (r_space == `BMC_SP_EXP);
  wire lb_done  = (r_space == `BMC_SP_EPROM) ? (wait_cnt == ws_last) : lb_ack_i; // R14

  // Watchdog on system and expansion cycles only
  wire lb_tmo   = lb_slow & (wait_cnt == TMO_LAST); // R15
  wire need_hi  = |r_be[3:2];

  // Cache write selection
  always @* begin
    wr_en   = 1'b0;
    wr_idx  = idx;
    wr_tag  = tag;
    wr_data = cpu_wdata_i;
    wr_mask = cpu_be_i;
    if (state == `BMC_ST_IDLE && cpu_req_i && cpu_we_i && cacheable &&
        (&cpu_be_i || hit)) begin
      // Full word installs, partial word merges into a hit
      wr_en = 1'b1; // R2
    end else if (state == `BMC_ST_MEM && mem_ack_i && !r_we && r_cache &&
                 par_ok) begin
      wr_en   = 1'b1; // R3 R6
      wr_idx  = r_idx;
      wr_tag  = r_tag;
      wr_data = mem_rdata_i;
      wr_mask = 4'hf;
    end
  end

  // Data field, byte-masked writes
  always @(posedge ref_clk_i) begin : data_wr
    integer b;
    for (b = 0; b < 4; b = b + 1) begin
      if (wr_en && wr_mask[b]) begin
        c_data[wr_idx][8*b +: 8] <= wr_data[8*b +: 8]; // R4
      end
    end
  end

  // Tag field and valid bits
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      c_valid <= {ENTRIES{1'b0}};
    end else if (wr_en) begin
      c_tag[wr_idx]   <= wr_tag; // R4
      c_valid[wr_idx] <= 1'b1;
    end
  end

  // Request sequencer
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      state       <= `BMC_ST_IDLE;
      r_we        <= 1'b0;
      r_addr      <= 32'h0;
      r_be        <= 4'h0;
      r_wdata     <= 32'h0;
      r_space     <= `BMC_SP_SYS;
      r_cache     <= 1'b0;
      hi_half     <= 1'b0;
      wait_cnt    <= {TMO_W{1'b0}};
      cpu_ack_o   <= 1'b0;
      cpu_err_o   <= 1'b0;
      cpu_rdata_o <= 32'h0;
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= 22'h0;
      mem_be_o    <= 4'h0;
      mem_wdata_o <= 32'h0;
      mem_wpar_o  <= 4'h0;
      lb_req_o    <= 1'b0;
      lb_we_o     <= 1'b0;
      lb_space_o  <= `BMC_SP_SYS;
      lb_addr_o   <= 24'h0;
      lb_be_o     <= 2'h0;
      lb_wdata_o  <= 16'h0;
      par_irq_o   <= 1'b0;
      tmo_irq_o   <= 1'b0;
    end else begin
      // Event outputs fall back low each cycle
      cpu_ack_o <= 1'b0;
      cpu_err_o <= 1'b0;
      par_irq_o <= 1'b0;
      tmo_irq_o <= 1'b0;
      case (state)
        `BMC_ST_IDLE: begin
          if (cpu_req_i) begin
            r_we    <= cpu_we_i;
            r_addr  <= cpu_addr_i;
            r_be    <= cpu_be_i;
            r_wdata <= cpu_wdata_i;
            r_space <= space;
            r_cache <= cacheable;
            if (hit && !cpu_we_i) begin
              // Answer on the next edge, no wait
              cpu_ack_o   <= 1'b1; // R1
              cpu_rdata_o <= c_data[idx];
            end else if (is_dram) begin
              mem_req_o   <= 1'b1; // R7
              mem_we_o    <= cpu_we_i;
              mem_addr_o  <= cpu_addr_i[`BMC_DRAM_LSB-1:`BMC_IDX_LSB];
              mem_be_o    <= cpu_be_i;
              mem_wdata_o <= cpu_wdata_i;
              mem_wpar_o  <= bmc_par4(cpu_wdata_i); // R9
              state       <= `BMC_ST_MEM;
            end else begin
              // Skip the low half when no low byte is wanted
              hi_half <= ~|cpu_be_i[1:0];
              state   <= `BMC_ST_LBSET;
            end
          end
        end
        `BMC_ST_MEM: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            cpu_ack_o <= 1'b1;
            state     <= `BMC_ST_IDLE;
            if (!r_we) begin
              cpu_rdata_o <= mem_rdata_i; // R3
              par_irq_o   <= ~par_ok; // R8
            end
          end
        end
        `BMC_ST_LBSET: begin
          // One 16-bit half per local bus cycle
          lb_req_o   <= 1'b1; // R7 R11
          lb_we_o    <= r_we;
          lb_space_o <= r_space;
          lb_addr_o  <= {r_addr[`BMC_DRAM_LSB-1:`BMC_IDX_LSB], hi_half, 1'b0};
          lb_be_o    <= hi_half ? r_be[3:2] : r_be[1:0];
          lb_wdata_o <= hi_half ? r_wdata[31:16] : r_wdata[15:0];
          wait_cnt   <= {TMO_W{1'b0}};
          state      <= `BMC_ST_LBWAIT;
        end
        `BMC_ST_LBWAIT: begin
          wait_cnt <= wait_cnt + {{(TMO_W-1){1'b0}}, 1'b1};
          if (lb_done) begin
            lb_req_o <= 1'b0; // R14
            // Read data lands in the half just fetched
            if (!r_we && hi_half) begin
              cpu_rdata_o[31:16] <= lb_rdata_i;
            end else if (!r_we) begin
              cpu_rdata_o[15:0] <= lb_rdata_i;
            end
            if (!hi_half && need_hi) begin
              hi_half <= 1'b1;
              state   <= `BMC_ST_LBSET;
            end else begin
              cpu_ack_o <= 1'b1;
              state     <= `BMC_ST_IDLE;
            end
          end else if (lb_tmo) begin
            // Silent device: end the access with an error
            lb_req_o  <= 1'b0; // R15
            cpu_ack_o <= 1'b1;
            cpu_err_o <= 1'b1;
            tmo_irq_o <= 1'b1;
            state     <= `BMC_ST_IDLE;
          end
        end
        default: begin
          state <= `BMC_ST_IDLE;
        end
      endcase
    end
  end

endmodule

//--- rtl/bmc_consts.vh
`ifndef BMC_CONSTS_VH
`define BMC_CONSTS_VH
// How it works
// R1 - A 16KB cache fronts DRAM; read hits answer with zero wait states.
// R2 - Every CPU write to DRAM also updates the matching cache entry.
// R3 - Read miss fetches from DRAM, returns the word and fills the entry (no fill here when read parity fails).
// R4 - 4K entries, each a 32-bit data word with an 8-bit tag.
// R5 - Stored tag compared with upper address bits; hit only on match.
// R6 - Direct mapped: index bits pick one entry; a fill replaces it.
// R7 - DRAM port is 32 bits wide; local bus toward system is 16 bits.
// R8 - Byte parity checked on DRAM data; an error pulses the parity request.
// R9 - One parity bit per byte made on writes; all four lanes checked on reads.
// R10 - DRAM decode covers two modules of 1, 2, 4 or 8MB, up to 16MB.
// R11 - 16-bit local bus carries system, expansion, EPROM and I/O accesses.
// R12 - EPROM is two sites, at most 128KB together.
// R13 - EPROM decoded at the top of memory in real and protected mode.
// R14 - EPROM accesses take three to six selectable wait states.
// R15 - System or expansion device silent for 10 ms ends access, pulses timeout.

// Cache geometry
`define BMC_IDX_W     12
`define BMC_TAG_W     8
`define BMC_IDX_LSB   2
`define BMC_CACHE_LSB 22
// Address map
`define BMC_ADDR_MSB  31
`define BMC_DRAM_LSB  24
`define BMC_EPROM_LSB 17
`define BMC_REAL_TOP  19
`define BMC_MB        25'h0100000
`define BMC_IOPG_MSB  15
`define BMC_IOPG_LSB  8
`define BMC_EXP_PAGE  8'h80
// Local bus spaces
`define BMC_SP_SYS    2'h0
`define BMC_SP_EXP    2'h1
`define BMC_SP_EPROM  2'h2
`define BMC_SP_IO     2'h3
// EPROM wait states
`define BMC_WS_MIN    3'h3
// Bus timeout
`define BMC_TMO_MS    10
`define BMC_CLK_MHZ   125
`define BMC_US_PER_MS 1000
`define BMC_TMO_CYC   (`BMC_TMO_MS * `BMC_US_PER_MS * `BMC_CLK_MHZ)
`define BMC_TMO_W     21
// Controller states
`define BMC_ST_IDLE   2'h0
`define BMC_ST_MEM    2'h1
`define BMC_ST_LBSET  2'h2
`define BMC_ST_LBWAIT 2'h3
`endif

//--- testbench/bmc_cache_assertions.sv
`timescale 1ns/1ps
module bmc_cache_assertions #(
  parameter TMO_CYCLES = 20
) (
  input wire logic        ref_clk_i, rst_i, cpu_req_i, cpu_ack_o, cpu_err_o, mem_req_o,
  input wire logic        mem_we_o, mem_ack_i, lb_req_o, par_irq_o, tmo_irq_o,
  input wire logic [1:0]  eprom_ws_i, lb_space_o,
  input wire logic [21:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o, mem_rdata_i,
  input wire logic [3:0]  mem_wpar_o, mem_rpar_i
);
  logic [31:0] cnt;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Odd parity of each byte
  function automatic logic [3:0] op(input logic [31:0] d);
    return {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0]};
  endfunction
  // Cycles a system or expansion request has stood
  always @(posedge ref_clk_i) begin
    if (rst_i || !lb_req_o || lb_space_o[1])
      cnt <= 32'h0;
    else
      cnt <= cnt + 32'h1;
  end
  chk_ack_one_cycle: assert property (cpu_ack_o && !cpu_req_i |=> !cpu_ack_o)
    else $error("ack too long");
  chk_err_with_ack: assert property (cpu_err_o |-> cpu_ack_o && tmo_irq_o) else $error("lone err");
  chk_dram_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
    && $stable(mem_wdata_o)) else $error("dram request moved");
  chk_dram_done_ack: assert property (mem_req_o && mem_ack_i |=> !mem_req_o && cpu_ack_o)
    else $error("dram done not acked");
  chk_write_parity: assert property (mem_req_o && mem_we_o |-> mem_wpar_o == op(mem_wdata_o))
    else $error("bad write parity");
  chk_parity_flag: assert property (mem_req_o && mem_ack_i && !mem_we_o
    && mem_rpar_i != op(mem_rdata_i) |=> par_irq_o) else $error("parity missed");
  chk_eprom_wait: assert property ($rose(lb_req_o) && lb_space_o == 2'h2 && eprom_ws_i == 2'h0
    |-> lb_req_o [*4] ##1 !lb_req_o) else $error("eprom wait wrong");
  chk_tmo_bound: assert property (cnt <= TMO_CYCLES) else $error("timeout late");
  chk_tmo_moment: assert property (tmo_irq_o |-> cnt == TMO_CYCLES) else $error("timeout early");
  cover property (cpu_ack_o && cpu_err_o);
  cover property (par_irq_o);
  cover property ($rose(lb_req_o) && lb_space_o == 2'h2);
endmodule
bind bmc_cache bmc_cache_assertions #(.TMO_CYCLES(TMO_CYCLES)) bmc_cache_assertions_inst (.*);

//--- testbench/bmc_mem_model.sv
`timescale 1ns/1ps
module bmc_mem_model (
  input  wire logic        ref_clk_i, req_i, we_i, bad_par_i,
  input  wire logic [1:0]  lat_i,
  input  wire logic [21:0] addr_i,
  input  wire logic [3:0]  be_i, wpar_i,
  input  wire logic [31:0] wdata_i,
  output logic             ack_o = 1'b0,
  output logic [31:0]      rdata_o = 32'h0,
  output logic [3:0]       rpar_o = 4'h0
);
  logic [31:0] mem [0:8191];
  logic [3:0]  par [0:8191];
  int          cnt = 0;
  // Answers after lat_i extra cycles; data lines toggle when idle
  always @(posedge ref_clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o) begin
      cnt <= cnt + 1;
      if (cnt >= lat_i) begin
        ack_o <= 1'b1;
        cnt <= 0;
        for (int i = 0; i < 4; i++)
          if (we_i && be_i[i]) begin
            mem[addr_i[12:0]][8*i+:8] <= wdata_i[8*i+:8];
            par[addr_i[12:0]][i] <= wpar_i[i];
          end
        rdata_o <= mem[addr_i[12:0]];
        rpar_o <= par[addr_i[12:0]] ^ {3'h0, bad_par_i};
      end
    end
  end
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i = 0, rst_i = 1, cpu_req_i = 0, cpu_we_i = 0, cpu_io_i = 0, real_mode_i = 0;
  logic cpu_ack_o, cpu_err_o, mem_req_o, mem_we_o, mem_ack_i, lb_req_o, lb_we_o, lb_ack_i = 0;
  logic par_irq_o, tmo_irq_o, bad_par = 0, lb_mute = 0, er, pe;
  logic [31:0] cpu_addr_i = 0, cpu_wdata_i = 0, cpu_rdata_o, mem_wdata_o, mem_rdata_i, q, a, d;
  logic [3:0]  cpu_be_i = 4'hf, mem_be_o, mem_wpar_o, mem_rpar_i;
  logic [1:0]  eprom_ws_i = 0, mod_en_i = 2'h1, mod0_size_i = 0, mod1_size_i = 0, lb_space_o;
  logic [1:0]  lb_be_o, lat_sel = 0;
  logic [21:0] mem_addr_o;
  logic [23:0] lb_addr_o;
  logic [15:0] lb_wdata_o, lb_rdata_i;
  logic [31:0] lw;
  logic [3:0]  lbe;
  logic [31:0] shadow [0:8191];
  int          n_errors = 0, n_tests = 0, lat, lb_cnt = 0, seed = 32'h36e3776b;
  always #4 ref_clk_i = ~ref_clk_i;
  bmc_cache #(.TMO_CYCLES(20)) bmc_cache_inst (.*);
  bmc_mem_model bmc_mem_model_inst (.ref_clk_i, .req_i(mem_req_o), .we_i(mem_we_o),
    .bad_par_i(bad_par), .lat_i(lat_sel), .addr_i(mem_addr_o), .be_i(mem_be_o),
    .wpar_i(mem_wpar_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i),
    .rpar_o(mem_rpar_i));
  // Local bus responder; silent toward system/expansion when muted
  assign lb_rdata_i = lb_req_o ? lb_addr_o[15:0] ^ 16'h5a5a : ~lb_addr_o[15:0];
  always @(negedge ref_clk_i) begin
    lb_ack_i <= lb_req_o && lb_cnt == 2 && !(lb_mute && !lb_space_o[1]);
    lb_cnt <= lb_req_o ? lb_cnt + 1 : 0;
    // Keep what each written half carried
    if (lb_req_o && lb_we_o && lb_cnt == 2) begin
      lw[16*lb_addr_o[1] +: 16] <= lb_wdata_o;
      lbe[2*lb_addr_o[1] +: 2] <= lb_be_o;
    end
  end
  // Word seen through two local bus halves
  function automatic logic [31:0] lbw(input logic [31:0] x);
    return {x[15:2], 2'h2, x[15:2], 2'h0} ^ 32'h5a5a5a5a;
  endfunction
  task check_data(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task check_flag(input logic got, exp);
    check_data({31'h0, got}, {31'h0, exp});
  endtask
  task complete_run;
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One CPU transfer; lat counts cycles from request to ack
  task op(input logic we, io, input logic [31:0] x, y, input logic [3:0] be);
    @(negedge ref_clk_i);
    cpu_req_i = 1;
    cpu_we_i = we;
    cpu_io_i = io;
    cpu_addr_i = x;
    cpu_wdata_i = y;
    cpu_be_i = be;
    @(negedge ref_clk_i);
    cpu_req_i = 0;
    lat = 1;
    pe = par_irq_o;
    while (cpu_ack_o !== 1'b1 && lat < 200) begin
      @(negedge ref_clk_i);
      lat++;
      pe |= par_irq_o;
    end
    if (lat >= 200) begin
      n_errors++;
      complete_run();
    end
    q = cpu_rdata_o;
    er = cpu_err_o;
  endtask
  task dram_rd(input logic [31:0] x, input logic hit);
    op(0, 0, x, 32'h0, 4'hf);
    check_data(q, shadow[x[14:2]]);
    check_flag(lat == 1, hit);
    check_flag(pe, 1'b0);
  endtask
  initial begin
    repeat (20) @(negedge ref_clk_i);
    rst_i = 0;
    // Random fills, evictions and merges
    for (int i = 0; i < 32; i++) begin
      a = ($random(seed) & 32'hff) << 2;
      d = $random(seed);
      lat_sel = $random(seed);
      op(1, 0, a, d, 4'hf);
      shadow[a[14:2]] = d;
      dram_rd(a, 1);
      op(1, 0, a ^ 32'h4000, ~d, 4'hf);
      shadow[a[14:2] ^ 13'h1000] = ~d;
      dram_rd(a, 0);
      dram_rd(a, 1);
      op(1, 0, a, 32'hffffffff, 4'h3);
      shadow[a[14:2]][15:0] = 16'hffff;
      dram_rd(a, 1);
      op(1, 0, a ^ 32'h4000, d, 4'hf);
      shadow[a[14:2] ^ 13'h1000] = d;
      dram_rd(a, 0);
    end
    // Corrupt parity on a miss: flagged, data returned, not kept
    op(1, 0, 32'h0, d, 4'hf);
    shadow[0] = d;
    op(1, 0, 32'h4000, 32'h0, 4'hf);
    shadow[13'h1000] = 32'h0;
    bad_par = 1;
    op(0, 0, 32'h0, 32'h0, 4'hf);
    bad_par = 0;
    check_data(q, shadow[0]);
    check_flag(pe, 1'b1);
    dram_rd(32'h0, 0);
    // EPROM at the top in both modes, every wait setting
    for (int w = 0; w < 4; w++) begin
      eprom_ws_i = w;
      real_mode_i = w[0];
      a = w[0] ? 32'h000e1234 : 32'hfffe5678;
      op(0, 0, a, 32'h0, 4'hf);
      check_data(q, lbw(a));
      check_data(lat, 11 + 2 * w);
    end
    real_mode_i = 0;
    // Silent system and expansion devices time out; on-board I/O does not
    lb_mute = 1;
    op(0, 0, 32'h02000000, 32'h0, 4'hf);
    check_flag(er, 1'b1);
    check_data(lat, 22);
    op(0, 1, 32'h00008010, 32'h0, 4'hf);
    check_flag(er, 1'b1);
    op(0, 1, 32'h00000010, 32'h0, 4'hf);
    check_flag(er, 1'b0);
    check_data(q, lbw(32'h10));
    lb_mute = 0;
    op(0, 1, 32'h00008010, 32'h0, 4'hf);
    check_data(q, lbw(32'h8010));
    // Local bus writes: both halves, then the high half alone
    op(1, 1, 32'h00000020, d, 4'hf);
    check_data(lw, d);
    check_data(lat, 9);
    op(1, 1, 32'h00000024, ~d, 4'h4);
    check_data(lw, {~d[31:16], d[15:0]});
    check_data(lbe, 4'h7);
    check_data(lat, 5);
    // Module size decides whether 1MB+ is DRAM
    op(0, 0, 32'h00100040, 32'h0, 4'hf);
    check_data(q, lbw(32'h00100040));
    mod0_size_i = 2'h1;
    op(1, 0, 32'h00100040, d, 4'hf);
    op(0, 0, 32'h00100040, 32'h0, 4'hf);
    check_data(q, d);
    check_flag(lat == 1, 1'b1);
    // Second module widens DRAM; above 4MB is not cached
    op(0, 0, 32'h00400040, 32'h0, 4'hf);
    check_data(q, lbw(32'h00400040));
    mod_en_i = 2'h3;
    mod1_size_i = 2'h3;
    op(1, 0, 32'h00400040, ~d, 4'hf);
    op(0, 0, 32'h00400040, 32'h0, 4'hf);
    check_data(q, ~d);
    check_flag(lat == 1, 1'b0);
    complete_run();
  end
endmodule
